// ===== design/pphp_dev.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - three-bit code decoded to one-hot status
// - status word on read bus unless fetching
// - status command answered by acknowledge
// - host trusts bits 1-7 only when busy bit clear
// - spare control bit zero, passed out latched
// - socket one when bit set, else two
// - nibble bit picks upper or lower write half
// - four-bit reads duplicated on both nibbles
// - nibble bit ignored for byte-wide targets
// - control strobe latches mode and high address
// - low strobe latches low byte, drives address
// - fetch command routes card data to bus
// - inverted fetch command forms fetch request
// - idle sequencer alternates fetch and program tests
// - missing card gives error, acknowledge, abandon
// - fetched byte ready sets done, pulses fetch_done_pulse_o
// - fetch release drops acknowledge, restores status
// - host releases fetch, then checks status
// - auto-fetch bit sets busy and requests read
// - done pulse clears auto request and busy
// - fetch after auto-fetch acknowledged within 1 us
// - host polls busy before fetching after auto
// - write strobes never acknowledged
module pphp_dev
  import pphp_pkg::*;
#(
  parameter int RD_CYC = CARD_RD_CYC,
  parameter int PG_CYC = PROG_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // host side
  pphp_if.dev bus,
  // personality cards
  input wire logic card_present_one_i,
  input wire logic card_present_two_i,
  input wire logic [7:0] card_rdata_i,
  input wire logic card_nib4_i,
  output logic [11:0] target_addr_out_o,
  output logic [7:0] prog_data_o,
  output logic card_read_o,
  output logic prog_pulse_o,
  // edge and status outputs
  output logic sock_sel_o,
  output logic nib_sel_o,
  output logic spare_ctrl_o,
  output logic fetch_done_pulse_o,
  output logic [7:0] status_word_o
);
  import pphp_pkg::*;

  typedef enum logic [5:0] {
    S_TFETCH = 6'h01,
    S_TPROG = 6'h02,
    S_CARD = 6'h04,
    S_READ = 6'h08,
    S_PROG = 6'h10,
    S_END = 6'h20
  } pphp_seq_t;

  // ***************************************
  // strobe capture
  // ***************************************
  logic [2:0] fall;
  logic wd_stb;
  logic ctl_stb;
  logic lo_stb;
  logic [7:0] din;

  pphp_fall_det #(.W(3)) u_fall (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sig_n_i({bus.lo_addr_strobe_n, bus.ctrl_hi_strobe_n, bus.wdata_strobe_n}),
    .fall_o(fall)
  );
  assign wd_stb = fall[0];
  assign ctl_stb = fall[1];
  assign lo_stb = fall[2];
  assign din = ~bus.host_wdata_n;

  logic auto_bit_reg;
  logic [3:0] hi_reg;
  logic [7:0] lo_reg;
  logic [7:0] wd_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      spare_ctrl_o <= MODE_RST[3];
      auto_bit_reg <= MODE_RST[2];
      sock_sel_o <= MODE_RST[1];
      nib_sel_o <= MODE_RST[0];
      hi_reg <= HI_RST;
    end else if (ctl_stb) begin
      spare_ctrl_o <= din[CTL_SPARE_BIT];
      auto_bit_reg <= din[CTL_AUTO_BIT];
      sock_sel_o <= din[CTL_SOCK_BIT];
      nib_sel_o <= din[CTL_NIB_BIT];
      hi_reg <= din[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lo_reg <= BYTE_RST;
    end else if (lo_stb) begin
      lo_reg <= din;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wd_reg <= BYTE_RST;
    end else if (wd_stb) begin
      wd_reg <= din;
    end
  end

  assign target_addr_out_o = {hi_reg, lo_reg};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prog_data_o <= BYTE_RST;
    end else if (!card_nib4_i) begin
      prog_data_o <= wd_reg;
    end else if (nib_sel_o) begin
      prog_data_o <= {4'h0, wd_reg[7:4]};
    end else begin
      prog_data_o <= {4'h0, wd_reg[3:0]};
    end
  end

  // ***************************************
  // requests
  // ***************************************
  pphp_seq_t seq_reg;
  logic fetch_req_reg;
  logic auto_req_reg;
  logic prog_req_reg;
  logic data_ready_reg;
  logic is_read_reg;
  logic err_reg;
  logic present;
  logic svc_fetch;
  logic [7:0] card_fmt;
  logic [7:0] rdata_reg;
  logic [15:0] cnt_reg;
  pphp_stat_t code_reg;
  logic [7:0] stat_dec;

  assign present = sock_sel_o ? card_present_one_i : card_present_two_i;
  assign svc_fetch = (fetch_req_reg & ~data_ready_reg) | auto_req_reg;
  assign card_fmt = card_nib4_i ? {card_rdata_i[3:0], card_rdata_i[3:0]}
                                : card_rdata_i;
  assign stat_dec = 8'(8'h01 << code_reg);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fetch_req_reg <= 1'b0;
    end else begin
      fetch_req_reg <= ~bus.host_fetch_cmd_n;
    end
  end

  // set terms come last so an event in the clearing cycle survives
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      auto_req_reg <= 1'b0;
    end else begin
      if (seq_reg == S_END && is_read_reg) begin
        auto_req_reg <= 1'b0;
      end
      if (ctl_stb && din[CTL_AUTO_BIT]) begin
        auto_req_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prog_req_reg <= 1'b0;
    end else begin
      if (seq_reg == S_END && !is_read_reg) begin
        prog_req_reg <= 1'b0;
      end
      if (wd_stb) begin
        prog_req_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_ready_reg <= 1'b0;
    end else begin
      if (wd_stb || ctl_stb || lo_stb) begin
        data_ready_reg <= 1'b0;
      end
      if (seq_reg == S_END && is_read_reg) begin
        data_ready_reg <= 1'b1;
      end
    end
  end

  // ***************************************
  // sequencer
  // ***************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      seq_reg <= S_TFETCH;
      is_read_reg <= 1'b0;
      err_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      rdata_reg <= BYTE_RST;
      card_read_o <= 1'b0;
      prog_pulse_o <= 1'b0;
      fetch_done_pulse_o <= 1'b0;
    end else begin
      fetch_done_pulse_o <= 1'b0;
      card_read_o <= 1'b0;
      prog_pulse_o <= 1'b0;
      unique case (seq_reg)
        S_TFETCH: begin
          if (svc_fetch) begin
            is_read_reg <= 1'b1;
            seq_reg <= S_CARD;
          end else begin
            seq_reg <= S_TPROG;
          end
        end
        S_TPROG: begin
          if (prog_req_reg) begin
            is_read_reg <= 1'b0;
            seq_reg <= S_CARD;
          end else begin
            seq_reg <= S_TFETCH;
          end
        end
        S_CARD: begin
          cnt_reg <= 16'h0000;
          err_reg <= ~present;
          if (!present) begin
            seq_reg <= S_END;
          end else if (is_read_reg) begin
            seq_reg <= S_READ;
          end else begin
            seq_reg <= S_PROG;
          end
        end
        S_READ: begin
          card_read_o <= 1'b1;
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(RD_CYC - 1)) begin
            rdata_reg <= card_fmt;
            seq_reg <= S_END;
          end
        end
        S_PROG: begin
          prog_pulse_o <= 1'b1;
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(PG_CYC - 1)) begin
            seq_reg <= S_END;
          end
        end
        S_END: begin
          fetch_done_pulse_o <= is_read_reg;
          seq_reg <= S_TFETCH;
        end
      endcase
    end
  end

  // ***************************************
  // status and host read bus
  // ***************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      code_reg <= ST_IDLE;
    end else begin
      if (seq_reg == S_CARD) begin
        code_reg <= ST_BUSY;
      end else if (seq_reg == S_END) begin
        code_reg <= err_reg ? ST_NO_CARD : ST_DONE_OK;
      end
      if (wd_stb || (ctl_stb && din[CTL_AUTO_BIT])) begin
        code_reg <= ST_BUSY;
      end
    end
  end

  logic ack_n_reg;
  logic [7:0] rbus_n_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_word_o <= 8'h00;
      rbus_n_reg <= 8'hFF;
      ack_n_reg <= 1'b1;
    end else begin
      status_word_o <= stat_dec;
      if (!fetch_req_reg) begin
        rbus_n_reg <= ~stat_dec;
      end else if (data_ready_reg) begin
        rbus_n_reg <= ~rdata_reg;
      end else begin
        rbus_n_reg <= ~card_fmt;
      end
      // write strobes play no part here
      ack_n_reg <= ~(~bus.host_stat_cmd_n | (~bus.host_fetch_cmd_n & fetch_req_reg
                                             & data_ready_reg));
    end
  end

  assign bus.host_ack_n = ack_n_reg;
  assign bus.host_rbus_n = rbus_n_reg;
endmodule
`default_nettype wire

// ===== design/pphp_fall_det.sv
`timescale 1ns/10ps
`default_nettype none
module pphp_fall_det #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // active-low strobes in, one-cycle pulses out
  input wire logic [W-1:0] sig_n_i,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] prev_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prev_reg <= '1;
      fall_o <= '0;
    end else begin
      prev_reg <= sig_n_i;
      fall_o <= prev_reg & ~sig_n_i;
    end
  end
endmodule
`default_nettype wire

// ===== design/pphp_host.sv
`timescale 1ns/10ps
`default_nettype none
module pphp_host
  import pphp_pkg::*;
#(
  parameter int STB_W = STB_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // link to device
  pphp_if.host bus,
  // register port
  input wire logic [1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o
);
  import pphp_pkg::*;

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_SETUP = 6'h02,
    H_STB = 6'h04,
    H_HOLD = 6'h08,
    H_RCMD = 6'h10,
    H_RREL = 6'h20
  } pphp_hst_t;
  typedef enum logic [4:0] {
    G_WR = 5'h01,
    G_ACTRL = 5'h02,
    G_POLL = 5'h04,
    G_FETCH = 5'h08,
    G_STAT = 5'h10
  } pphp_stg_t;

  pphp_hst_t st_reg;
  pphp_stg_t stg_reg;
  pphp_op_t op;
  logic [2:0] sel_reg;
  logic [15:0] cnt_reg;
  logic [7:0] cap_reg;
  logic [7:0] result_reg;
  logic [7:0] stat_reg;
  logic [7:0] wbyte;
  logic busy;

  assign op = pphp_op_t'(wdata_i[10:8]);
  assign busy = (st_reg != H_IDLE);
  // spare control bit always sent as zero
  assign wbyte = (op == OP_CTRL || op == OP_AUTO) ?
                 {1'b0, (op == OP_AUTO) | wdata_i[6], wdata_i[5:0]} : wdata_i[7:0];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= H_IDLE;
      stg_reg <= G_WR;
      sel_reg <= 3'h0;
      cnt_reg <= 16'h0000;
      cap_reg <= 8'h00;
      result_reg <= 8'h00;
      stat_reg <= 8'h00;
      bus.host_wdata_n <= 8'hFF;
      bus.wdata_strobe_n <= 1'b1;
      bus.ctrl_hi_strobe_n <= 1'b1;
      bus.lo_addr_strobe_n <= 1'b1;
      bus.host_fetch_cmd_n <= 1'b1;
      bus.host_stat_cmd_n <= 1'b1;
    end else begin
      unique case (st_reg)
        H_IDLE: begin
          if (wr_i && addr_i == HR_CMD) begin
            bus.host_wdata_n <= ~wbyte;
            unique case (op)
              OP_CTRL, OP_LOADDR, OP_WDATA, OP_AUTO: begin
                stg_reg <= (op == OP_AUTO) ? G_ACTRL : G_WR;
                sel_reg <= (op == OP_WDATA) ? 3'h1 : (op == OP_LOADDR) ? 3'h4 : 3'h2;
                st_reg <= H_SETUP;
              end
              OP_STATUS: begin
                stg_reg <= G_STAT;
                bus.host_stat_cmd_n <= 1'b0;
                st_reg <= H_RCMD;
              end
              OP_FETCH: begin
                stg_reg <= G_FETCH;
                bus.host_fetch_cmd_n <= 1'b0;
                st_reg <= H_RCMD;
              end
              default: begin
                st_reg <= H_IDLE;
              end
            endcase
          end
        end
        H_SETUP: begin
          cnt_reg <= 16'h0000;
          bus.wdata_strobe_n <= ~sel_reg[0];
          bus.ctrl_hi_strobe_n <= ~sel_reg[1];
          bus.lo_addr_strobe_n <= ~sel_reg[2];
          st_reg <= H_STB;
        end
        H_STB: begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(STB_W - 1)) begin
            bus.wdata_strobe_n <= 1'b1;
            bus.ctrl_hi_strobe_n <= 1'b1;
            bus.lo_addr_strobe_n <= 1'b1;
            st_reg <= H_HOLD;
          end
        end
        H_HOLD: begin
          // no acknowledge comes back for writes
          if (stg_reg == G_ACTRL) begin
            stg_reg <= G_POLL;
            bus.host_stat_cmd_n <= 1'b0;
            st_reg <= H_RCMD;
          end else begin
            st_reg <= H_IDLE;
          end
        end
        H_RCMD: begin
          if (!bus.host_ack_n) begin
            cap_reg <= ~bus.host_rbus_n;
            bus.host_stat_cmd_n <= 1'b1;
            bus.host_fetch_cmd_n <= 1'b1;
            st_reg <= H_RREL;
          end
        end
        H_RREL: begin
          if (bus.host_ack_n) begin
            unique case (stg_reg)
              G_POLL: begin
                if (cap_reg[STAT_BUSY_BIT]) begin
                  bus.host_stat_cmd_n <= 1'b0;
                end else begin
                  stg_reg <= G_FETCH;
                  bus.host_fetch_cmd_n <= 1'b0;
                end
                st_reg <= H_RCMD;
              end
              G_FETCH: begin
                result_reg <= cap_reg;
                stg_reg <= G_STAT;
                bus.host_stat_cmd_n <= 1'b0;
                st_reg <= H_RCMD;
              end
              default: begin
                // other bits mean nothing while busy is shown
                stat_reg <= cap_reg[STAT_BUSY_BIT] ? 8'h01 : cap_reg;
                st_reg <= H_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i && addr_i == HR_RESULT) begin
      rdata_o <= {8'h00, result_reg};
    end else if (rd_i && addr_i == HR_STATUS) begin
      rdata_o <= {7'h00, busy, stat_reg};
    end else begin
      rdata_o <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ===== design/pphp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pphp_if;
  logic [7:0] host_wdata_n;
  logic wdata_strobe_n;
  logic ctrl_hi_strobe_n;
  logic lo_addr_strobe_n;
  logic host_fetch_cmd_n;
  logic host_stat_cmd_n;
  logic host_ack_n;
  logic [7:0] host_rbus_n;
  modport dev (
    input host_wdata_n, wdata_strobe_n, ctrl_hi_strobe_n, lo_addr_strobe_n,
    input host_fetch_cmd_n, host_stat_cmd_n,
    output host_ack_n, host_rbus_n
  );
  modport host (
    output host_wdata_n, wdata_strobe_n, ctrl_hi_strobe_n, lo_addr_strobe_n,
    output host_fetch_cmd_n, host_stat_cmd_n,
    input host_ack_n, host_rbus_n
  );
endinterface
`default_nettype wire

// ===== design/pphp_pkg.sv
package pphp_pkg;
  // ***************************************
  // timing
  // ***************************************
  localparam int CLK_MHZ = 100;
  localparam int ACK_MAX_NS = 1000;
  localparam int ACK_MAX_CYC = (ACK_MAX_NS * CLK_MHZ) / 1000;
  localparam int CARD_RD_NS = 1000;
  localparam int CARD_RD_CYC = (CARD_RD_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_NS = 2000;
  localparam int PROG_CYC = (PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int STB_NS = 100;
  localparam int STB_CYC = (STB_NS * CLK_MHZ + 999) / 1000;
  // ***************************************
  // control/high-address byte layout
  // ***************************************
  localparam int CTL_SPARE_BIT = 7;
  localparam int CTL_AUTO_BIT = 6;
  localparam int CTL_SOCK_BIT = 5;
  localparam int CTL_NIB_BIT = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [3:0] HI_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // ***************************************
  // status codes, one bit of the word each
  // ***************************************
  typedef enum logic [2:0] {
    ST_BUSY = 3'h0,
    ST_DONE_OK = 3'h1,
    ST_NO_CARD = 3'h2,
    ST_IDLE = 3'h3
  } pphp_stat_t;
  // ***************************************
  // controller registers and orders
  // ***************************************
  localparam logic [1:0] HR_CMD = 2'h0;
  localparam logic [1:0] HR_RESULT = 2'h1;
  localparam logic [1:0] HR_STATUS = 2'h2;
  typedef enum logic [2:0] {
    OP_CTRL = 3'h0,
    OP_LOADDR = 3'h1,
    OP_WDATA = 3'h2,
    OP_STATUS = 3'h3,
    OP_FETCH = 3'h4,
    OP_AUTO = 3'h5
  } pphp_op_t;
endpackage

// ===== tb/pphp_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pphp_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // link signals
  input wire logic [7:0] host_wdata_n,
  input wire logic wdata_strobe_n,
  input wire logic ctrl_hi_strobe_n,
  input wire logic lo_addr_strobe_n,
  input wire logic host_fetch_cmd_n,
  input wire logic host_stat_cmd_n,
  input wire logic host_ack_n,
  input wire logic [7:0] host_rbus_n
);
  localparam int ACK_WAIT = 100;
  localparam int BUSY_WAIT = 400;
  logic [1:0] live_reg;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ***************************************
  // cycles since reset release, saturating
  // ***************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      live_reg <= 2'h0;
    end else if (live_reg != 2'h3) begin
      live_reg <= live_reg + 2'h1;
    end
  end
  // ***************************************
  // properties
  // ***************************************
  property p_idle;
    $fell(reset_i) |-> host_rbus_n == 8'hFF && &{wdata_strobe_n, ctrl_hi_strobe_n,
      lo_addr_strobe_n, host_fetch_cmd_n, host_stat_cmd_n, host_ack_n};
  endproperty
  a_idle: assert property (p_idle) else $error("link not idle after reset");
  property p_onehot;
    live_reg == 2'h3 && host_fetch_cmd_n && $past(host_fetch_cmd_n) && $past(host_fetch_cmd_n, 2)
      |-> $onehot(~host_rbus_n);
  endproperty
  a_onehot: assert property (p_onehot) else $error("status word not one-hot");
  property p_stat_ack;
    $fell(host_stat_cmd_n) && host_fetch_cmd_n |=> !host_ack_n;
  endproperty
  a_stat_ack: assert property (p_stat_ack) else $error("status command not answered");
  property p_fetch_ack;
    $fell(host_fetch_cmd_n) |-> ##[1:ACK_WAIT] !host_ack_n;
  endproperty
  a_fetch_ack: assert property (p_fetch_ack) else $error("fetch not answered");
  property p_data_hold;
    !host_fetch_cmd_n && !host_ack_n |=> $stable(host_rbus_n);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("fetched byte moved");
  property p_rel_ack;
    $rose(host_fetch_cmd_n) |=> host_ack_n;
  endproperty
  a_rel_ack: assert property (p_rel_ack) else $error("answer held after release");
  property p_rel_stat;
    $rose(host_fetch_cmd_n) |-> ##2 $onehot(~host_rbus_n);
  endproperty
  a_rel_stat: assert property (p_rel_stat) else $error("status not restored");
  property p_no_wr_ack;
    (!lo_addr_strobe_n || !wdata_strobe_n) && host_fetch_cmd_n && host_stat_cmd_n
      && $past(host_fetch_cmd_n) |-> host_ack_n;
  endproperty
  a_no_wr_ack: assert property (p_no_wr_ack) else $error("write strobe answered");
  property p_busy_set;
    ($fell(ctrl_hi_strobe_n) && !host_wdata_n[6]) || $fell(wdata_strobe_n)
      |-> ##[1:4] !host_rbus_n[0];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not raised");
  property p_busy_end;
    $fell(host_rbus_n[0]) && live_reg == 2'h3 && host_fetch_cmd_n && $past(host_fetch_cmd_n)
      && $past(host_fetch_cmd_n, 2) |-> ##[1:BUSY_WAIT] host_rbus_n[0];
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy never cleared");
  c_stat: cover property ($fell(host_stat_cmd_n) ##1 !host_ack_n);
  c_fetch: cover property ($fell(host_fetch_cmd_n) ##[1:ACK_WAIT] !host_ack_n);
  c_auto: cover property ($fell(ctrl_hi_strobe_n) && !host_wdata_n[6]);
endmodule
`default_nettype wire

// ===== tb/tb_prom_programmer_host_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_prom_programmer_host_port;
  import pphp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] rdata;
  logic pres1 = 1'b1;
  logic pres2 = 1'b1;
  logic [7:0] cdata = 8'h00;
  logic nib4 = 1'b0;
  logic [11:0] taddr;
  logic [7:0] pdata;
  logic sock;
  logic nib;
  logic spare;
  logic [7:0] sword;
  logic rd_on;
  logic pg_on;
  logic dn_on;
  int n_rd = 0;
  int n_pg = 0;
  int n_dn = 0;
  localparam int T_RD = 3;
  localparam int T_PG = 4;
  int num_errors = 0;
  int check_count = 0;
  pphp_if bus_if ();
  always #5 clk_i = ~clk_i;
  // cycles of card read, program time and done pulses seen so far
  always @(posedge clk_i) begin
    n_rd <= n_rd + ((rd_on === 1'b1) ? 1 : 0);
    n_pg <= n_pg + ((pg_on === 1'b1) ? 1 : 0);
    n_dn <= n_dn + ((dn_on === 1'b1) ? 1 : 0);
  end
  // ***************************************
  // both ends and the link checker
  // ***************************************
  pphp_dev #(.RD_CYC(T_RD), .PG_CYC(T_PG)) i_pphp_dev (.clk_i(clk_i), .reset_i(reset_i),
    .bus(bus_if.dev), .card_present_one_i(pres1), .card_present_two_i(pres2),
    .card_rdata_i(cdata), .card_nib4_i(nib4), .target_addr_out_o(taddr), .prog_data_o(pdata),
    .card_read_o(rd_on), .prog_pulse_o(pg_on), .sock_sel_o(sock), .nib_sel_o(nib),
    .spare_ctrl_o(spare), .fetch_done_pulse_o(dn_on), .status_word_o(sword));
  pphp_host #(.STB_W(2)) i_pphp_host (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if.host),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata));
  pphp_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .host_wdata_n(bus_if.host_wdata_n),
    .wdata_strobe_n(bus_if.wdata_strobe_n), .ctrl_hi_strobe_n(bus_if.ctrl_hi_strobe_n),
    .lo_addr_strobe_n(bus_if.lo_addr_strobe_n), .host_fetch_cmd_n(bus_if.host_fetch_cmd_n),
    .host_stat_cmd_n(bus_if.host_stat_cmd_n), .host_ack_n(bus_if.host_ack_n),
    .host_rbus_n(bus_if.host_rbus_n));
  // ***************************************
  // tasks and expectations
  // ***************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask
  task automatic run_op(input pphp_op_t o, input logic [7:0] b);
    logic [15:0] s;
    int n;
    wr(HR_CMD, {5'h00, o, b});
    n = 0;
    s = 16'h0100;
    while (s[8] === 1'b1 && n < 2000) begin
      rd(HR_STATUS, s);
      n++;
    end
    chk({15'h0000, s[8]}, 16'h0000, "op ends");
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] d, input logic n4);
    return n4 ? {d[3:0], d[3:0]} : d;
  endfunction
  function automatic logic [7:0] exp_pg(input logic [7:0] d, input logic n4, input logic ns);
    return !n4 ? d : (ns ? {4'h0, d[7:4]} : {4'h0, d[3:0]});
  endfunction
  initial begin
    #400000;
    num_errors++;
    $display("BAD %0t watchdog", $time);
    close_out();
  end
  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    logic [15:0] r;
    logic [7:0] ctl;
    logic [7:0] lo;
    logic [7:0] d;
    logic ok;
    int k;
    int b_rd;
    int b_pg;
    int b_dn;
    void'($urandom(59));
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(HR_STATUS, r);
    chk(r, 16'h0000, "reset status");
    run_op(OP_STATUS, 8'h00);
    rd(HR_STATUS, r);
    chk(r, 16'h0008, "idle status");
    chk({8'h00, bus_if.host_rbus_n}, 16'h00F7, "idle bus");
    rd(2'h3, r);
    chk(r, 16'h0000, "unmapped read");
    wr(HR_STATUS, 16'hFFFF);
    rd(HR_STATUS, r);
    chk(r, 16'h0008, "status read only");
    run_op(OP_STATUS, 8'h00);
    $display("test 0 done");
    for (int i = 1; i <= 15; i++) begin
      k = i % 3;
      lo = (i == 1) ? 8'hFF : 8'($urandom);
      d = 8'($urandom);
      ctl = 8'($urandom);
      ctl[7] = 1'b0;
      ctl[6] = (k == 1);
      if (i == 1) begin
        ctl[3:0] = 4'hF;
      end
      @(posedge clk_i);
      pres1 <= (i == 3 || i == 4) ? !ctl[5] : (k == 2 || $urandom_range(3) != 0);
      pres2 <= (i == 3 || i == 4) ? ctl[5] : (k == 2 || $urandom_range(3) != 0);
      nib4 <= 1'($urandom);
      cdata <= d;
      b_rd = n_rd;
      b_pg = n_pg;
      b_dn = n_dn;
      run_op(OP_LOADDR, lo);
      run_op(k == 1 ? OP_AUTO : OP_CTRL, ctl);
      chk({4'h0, taddr}, {4'h0, ctl[3:0], lo}, "address");
      chk({13'h0, spare, sock, nib}, {13'h0, 1'b0, ctl[5], ctl[4]}, "ctrl bits");
      ok = ctl[5] ? pres1 : pres2;
      if (k == 2) begin
        run_op(OP_WDATA, d);
        chk({8'h00, pdata & (nib4 ? 8'h0F : 8'hFF)}, {8'h00, exp_pg(d, nib4, ctl[4])},
          "prog data");
        r = 16'h0001;
        for (int n = 0; n < 50 && r[0] === 1'b1; n++) begin
          run_op(OP_STATUS, 8'h00);
          rd(HR_STATUS, r);
        end
      end else begin
        if (k == 0) begin
          run_op(OP_FETCH, 8'h00);
        end
        rd(HR_RESULT, r);
        if (ok) begin
          chk(r, {8'h00, exp_rd(d, nib4)}, "read data");
        end
      end
      rd(HR_STATUS, r);
      chk(r, (k == 2 || ok) ? 16'h0002 : 16'h0004, "end status");
      chk({~bus_if.host_rbus_n, sword}, {2{(k == 2 || ok) ? 8'h02 : 8'h04}},
        "bus polarity");
      chk({4'h0, 4'(n_rd - b_rd), 4'(n_pg - b_pg), 4'(n_dn - b_dn)},
        {4'h0, 4'((k != 2 && ok) ? T_RD : 0), 4'((k == 2) ? T_PG : 0), 4'(k != 2)},
        "card strobes");
      if (ok && k == 0) begin
        @(posedge clk_i);
        cdata <= ~d;
        run_op(OP_FETCH, 8'h00);
        rd(HR_RESULT, r);
        chk(r, {8'h00, exp_rd(d, nib4)}, "stored byte");
      end
      $display("test %0d done", i);
    end
    close_out();
  end
endmodule
`default_nettype wire
